// ### hdl/encoder_turns_and_line_scaling.sv
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "enc_scale_cfg.svh"
// Function
// - turns zero holds revolution counter zero
// - nonzero turns masks counter to that width
// - turns above 16 clamp to 16
// - comms rotary: turns is multi-turn count
// - linear geometry: counter unmasked full 16 bits
// - linear comms: turns is period ratio
// - settings may load from absolute encoder
// - scaling derived from lines per revolution
// - equivalent lines depend on encoder type
// - linear revolution equals pole pitch times poles; pole count is only stored and read back, not used
// - sincos resolution adds interpolation bits
// - rotary comms resolution from single-turn bits
// - rotary comms forces lines power of two
// - changing lines raises reinit trip
// - linear non power two lowers sample rate at switch select 1 or 2
// - counter rolls over both directions
module encoder_turns_and_line_scaling (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // position front end, same clock
   input wire enc_scale_pkg::step_t step_in,
   input wire enc_scale_pkg::autoload_t autoload_in,
   input wire logic [1:0] switch_freq_sel,
   // outputs
   output logic [15:0] revolution_counter,
   output logic reinit_trip,
   output logic sample_rate_reduced,
   output logic irq
);
   import enc_scale_pkg::*;

   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   function automatic logic is_comms(input logic [3:0] t);
      return t == sincos_async_comms_type || t == sincos_bidir_comms_type || t == sincos_sync_serial_type;
   endfunction
   function automatic logic is_pow2(input logic [15:0] v);
      return v != 16'h0000 && (v & (v - 16'h0001)) == 16'h0000;
   endfunction
   // round down to a power of two inside 2..32768
   function automatic logic [15:0] force_pow2(input logic [15:0] v);
      logic [15:0] r;
      r = `LINES_P2_MIN;
      for (int i = 1; i < 16; i++) begin
         if (v[i]) begin
            r = 16'h0001 << i;
         end
      end
      return r;
   endfunction
   function automatic logic [4:0] log2_16(input logic [15:0] v);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 0; i < 16; i++) begin
         if (v[i]) begin
            r = 5'(i);
         end
      end
      return r;
   endfunction

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [3:0] enc_type_q;
   logic [1:0] encoder_geometry_select;
   logic [7:0] turns_bits_setting;
   logic [15:0] lines_per_rev_setting;
   logic [5:0] single_turn_comms_bits;
   logic [7:0] pole_count_setting;
   logic [3:0] interp_bits_q;
   logic autoload_en_q;
   logic [3:0] irq_stat_q;
   logic [3:0] irq_mask_q;
   logic [15:0] rev_q;
   logic trip_q;
   logic rate_q;

   wire wr_en = psel && penable && pwrite;
   wire rd_en = psel && !penable && !pwrite;
   wire linear = encoder_geometry_select == 2'h0;
   wire rotary_comms = is_comms(enc_type_q) && !linear;
   wire [15:0] lines_wr = rotary_comms ? force_pow2(pwdata[15:0]) : pwdata[15:0];
   wire [15:0] lines_ld = rotary_comms ? force_pow2(autoload_in.lines) : autoload_in.lines;
   wire wr_lines = wr_en && paddr == `OFS_LINES && lines_wr != lines_per_rev_setting;
   wire ld_lines = autoload_en_q && autoload_in.valid && lines_ld != lines_per_rev_setting;

   // effective turns bits: 0..16, linear always 16
   logic [4:0] turn_bits;
   always_comb begin
      if (linear) begin
         turn_bits = `MAX_TURN_BITS;
      end else if (turns_bits_setting > 8'(`MAX_TURN_BITS)) begin
         turn_bits = `MAX_TURN_BITS;
      end else begin
         turn_bits = turns_bits_setting[4:0];
      end
   end
   wire [15:0] rev_mask = 16'((17'h00001 << turn_bits) - 17'h00001);

   // equivalent lines: fd/fr types count half the lines
   logic [15:0] equiv_lines_per_rev;
   always_comb begin
      unique case (enc_type_q)
         freq_dir_type, fwd_rev_type, freq_dir_servo_type, fwd_rev_servo_type:
            equiv_lines_per_rev = lines_per_rev_setting >> 1;
         default: equiv_lines_per_rev = lines_per_rev_setting;
      endcase
   end
   // scale word: resolution bits per rev, equivalent lines per rev
   logic [5:0] res_bits;
   always_comb begin
      if (rotary_comms) begin
         res_bits = single_turn_comms_bits;
      end else if (enc_type_q >= 4'(sincos_type)) begin
         res_bits = 6'(log2_16(equiv_lines_per_rev)) + 6'(interp_bits_q);
      end else begin
         res_bits = 6'(log2_16(equiv_lines_per_rev)) + 6'h02;
      end
   end

   // ----------------------------------------
   // configuration writes and autoload
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enc_type_q <= 4'h0;
         encoder_geometry_select <= 2'h1;
         autoload_en_q <= 1'b0;
         interp_bits_q <= `INTERP_NOM;
         turns_bits_setting <= `RST_TURNS;
         lines_per_rev_setting <= `RST_LINES;
         single_turn_comms_bits <= 6'h00;
         pole_count_setting <= `RST_POLES;
      end else begin
         if (wr_en && paddr == `OFS_CTRL) begin
            enc_type_q <= (pwdata[3:0] > 4'(sincos_sync_serial_type)) ? enc_type_q : pwdata[3:0];
            encoder_geometry_select <= pwdata[5:4];
            autoload_en_q <= pwdata[8];
            interp_bits_q <= (pwdata[15:12] > `INTERP_MAX) ? `INTERP_MAX : pwdata[15:12];
         end
         if (wr_en && paddr == `OFS_TURNS) begin
            turns_bits_setting <= pwdata[7:0];
         end
         if (wr_en && paddr == `OFS_COMMS) begin
            single_turn_comms_bits <= (pwdata[5:0] > 6'h20) ? 6'h20 : pwdata[5:0];
         end
         if (wr_en && paddr == `OFS_POLES) begin
            pole_count_setting <= pwdata[7:0];
         end
         if (wr_en && paddr == `OFS_LINES) begin
            lines_per_rev_setting <= lines_wr;
         end
         if (autoload_en_q && autoload_in.valid) begin
            turns_bits_setting <= autoload_in.turns;
            lines_per_rev_setting <= lines_ld;
         end
      end
   end

   // ----------------------------------------
   // revolution counter
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rev_q <= 16'h0000;
      end else if (turn_bits == 5'h00) begin
         rev_q <= 16'h0000;
      end else if (step_in.step) begin
         if (step_in.dir_down) begin
            rev_q <= (rev_q - 16'h0001) & rev_mask;
         end else begin
            rev_q <= (rev_q + 16'h0001) & rev_mask;
         end
      end else begin
         rev_q <= rev_q & rev_mask;
      end
   end
   wire wrap_ev = step_in.step && turn_bits != 5'h00 &&
      (step_in.dir_down ? rev_q == 16'h0000 : rev_q == rev_mask);

   // ----------------------------------------
   // trip and sample-rate limit
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trip_q <= 1'b0;
      end else if (wr_lines || ld_lines) begin
         trip_q <= 1'b1;
      end else if (wr_en && paddr == `OFS_STATUS && pwdata[`BIT_REINIT]) begin
         trip_q <= 1'b0;
      end
   end
   // switching select: 0=3k,1=6k,2=12k,3=16k
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rate_q <= 1'b0;
      end else begin
         rate_q <= linear && !is_pow2(lines_per_rev_setting) &&
            (switch_freq_sel == 2'h1 || switch_freq_sel == 2'h2);
      end
   end

   // ----------------------------------------
   // interrupts: sticky, write one to clear, set wins
   // ----------------------------------------
   wire [3:0] ev = {!rate_q && linear && !is_pow2(lines_per_rev_setting),
      autoload_en_q && autoload_in.valid, wrap_ev, wr_lines || ld_lines};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_q <= 4'h0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~((wr_en && paddr == `OFS_IRQ_STAT) ? pwdata[3:0] : 4'h0)) | ev;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_q <= 4'h0;
         irq <= 1'b0;
      end else begin
         if (wr_en && paddr == `OFS_IRQ_MASK) begin
            irq_mask_q <= pwdata[3:0];
         end
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   // ----------------------------------------
   // apb read, one wait-free access
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (rd_en) begin
         unique case (paddr)
            `OFS_CTRL: prdata <= {16'h0000, interp_bits_q, 3'h0, autoload_en_q, 2'h0,
               encoder_geometry_select, enc_type_q};
            `OFS_TURNS: prdata <= {24'h000000, turns_bits_setting};
            `OFS_LINES: prdata <= {16'h0000, lines_per_rev_setting};
            `OFS_COMMS: prdata <= {26'h0000000, single_turn_comms_bits};
            `OFS_POLES: prdata <= {24'h000000, pole_count_setting};
            `OFS_STATUS: prdata <= {28'h0000000, rate_q, 2'h0, trip_q};
            `OFS_IRQ_STAT: prdata <= {28'h0000000, irq_stat_q};
            `OFS_IRQ_MASK: prdata <= {28'h0000000, irq_mask_q};
            `OFS_REVS: prdata <= {16'h0000, rev_q};
            `OFS_SCALE: prdata <= {10'h000, res_bits, equiv_lines_per_rev};
            default: prdata <= 32'h00000000;
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && (paddr > `OFS_SCALE || paddr[1:0] != 2'h0);
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         revolution_counter <= 16'h0000;
         reinit_trip <= 1'b0;
         sample_rate_reduced <= 1'b0;
      end else begin
         revolution_counter <= rev_q;
         reinit_trip <= trip_q;
         sample_rate_reduced <= rate_q;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_ZERO_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      turn_bits == 5'h00 |=> rev_q == 16'h0000) else $error("counter not held at zero");
   AST_MASK_LIMIT: assert property (@(posedge pclk) disable iff (!presetn)
      (rev_q & ~rev_mask) == 16'h0000 || $changed(turn_bits)) else $error("counter above mask");
   AST_CLAMP16: assert property (@(posedge pclk) disable iff (!presetn)
      !linear && turns_bits_setting > 8'h10 |-> turn_bits == 5'h10) else $error("turns not clamped");
   AST_LINEAR_FULL: assert property (@(posedge pclk) disable iff (!presetn)
      linear |-> rev_mask == 16'hFFFF) else $error("linear counter masked");
   AST_UP_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
      step_in.step && !step_in.dir_down && turn_bits != 5'h00 && rev_q == rev_mask && $stable(turn_bits)
      |=> rev_q == 16'h0000 || $changed(turn_bits)) else $error("up wrap wrong");
   AST_DOWN_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
      step_in.step && step_in.dir_down && turn_bits != 5'h00 && rev_q == 16'h0000
      |=> rev_q == $past(rev_mask) || $changed(turn_bits)) else $error("down wrap wrong");
   AST_POW2: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && paddr == `OFS_LINES && rotary_comms |=> is_pow2(lines_per_rev_setting) &&
      lines_per_rev_setting >= 16'h0002) else $error("lines not power of two");
   AST_TRIP: assert property (@(posedge pclk) disable iff (!presetn)
      wr_lines |=> ##1 reinit_trip) else $error("no trip on lines change");
   AST_RATE: assert property (@(posedge pclk) disable iff (!presetn)
      linear && !is_pow2(lines_per_rev_setting) && switch_freq_sel == 2'h1 && $stable(lines_per_rev_setting)
      && $stable(encoder_geometry_select) |=> rate_q) else $error("rate not reduced");
endmodule // encoder_turns_and_line_scaling

// ### hdl/enc_scale_cfg.svh
`ifndef ENC_SCALE_CFG_SVH
`define ENC_SCALE_CFG_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL 12'h000
`define OFS_TURNS 12'h004
`define OFS_LINES 12'h008
`define OFS_COMMS 12'h00C
`define OFS_POLES 12'h010
`define OFS_STATUS 12'h014
`define OFS_IRQ_STAT 12'h018
`define OFS_IRQ_MASK 12'h01C
`define OFS_REVS 12'h020
`define OFS_SCALE 12'h024
// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define RST_TURNS 8'h10
`define RST_LINES 16'h1000
`define RST_POLES 8'h02
`define MAX_TURN_BITS 5'h10
`define LINES_P2_MIN 16'h0002
`define LINES_P2_MAX 16'h8000
`define INTERP_NOM 4'hA
`define INTERP_MAX 4'hB
// ----------------------------------------
// status / irq bit positions
// ----------------------------------------
`define BIT_REINIT 0
`define BIT_WRAP 1
`define BIT_AUTOLOAD 2
`define BIT_RATE_LIMIT 3
`endif

// ### hdl/enc_scale_pkg.sv
package enc_scale_pkg;
   // encoder feedback types
   typedef enum logic [3:0] {
      quadrature_type, freq_dir_type, fwd_rev_type,
      quadrature_servo_type, freq_dir_servo_type, fwd_rev_servo_type,
      sincos_type, sincos_async_comms_type, sincos_bidir_comms_type, sincos_sync_serial_type
   } enc_type_t;
   // incremental count pulses from the position front end
   typedef struct packed {
      logic step;
      logic dir_down;
   } step_t;
   // settings loaded from an absolute encoder
   typedef struct packed {
      logic valid;
      logic [7:0] turns;
      logic [15:0] lines;
   } autoload_t;
endpackage

// ### verification/enc_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// encoder far side: boundary pulses and autoload
// ----------------------------------------
module enc_model (
   // clock
   input wire logic pclk,
   // to the position front end
   output enc_scale_pkg::step_t step_out,
   output enc_scale_pkg::autoload_t load_out
);
   import enc_scale_pkg::*;
   // idle fields carry junk, never a clean value
   initial begin
      step_out = '0;
      load_out = '{valid: 1'b0, turns: 8'hA5, lines: 16'h5A5A};
   end
   // n boundary crossings, one every other cycle
   task automatic turn(input int n, input logic down);
      repeat (n) begin
         @(posedge pclk);
         step_out <= '{step: 1'b1, dir_down: down};
         @(posedge pclk);
         step_out <= '{step: 1'b0, dir_down: ~down};
      end
   endtask
   // one settings word read out of an absolute encoder
   task automatic load(input logic [7:0] t, input logic [15:0] l);
      @(posedge pclk);
      load_out <= '{valid: 1'b1, turns: t, lines: l};
      @(posedge pclk);
      load_out <= '{valid: 1'b0, turns: ~t, lines: ~l};
   endtask
endmodule // enc_model

// ### verification/testbench.sv
`timescale 1ns/1ps
`include "enc_scale_cfg.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module testbench;
   import enc_scale_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [1:0] switch_freq_sel = 2'h0;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, reinit_trip, sample_rate_reduced, irq;
   wire logic [15:0] revolution_counter;
   step_t step_in;
   autoload_t autoload_in;
   int err_total = 0, comparisons = 0, n;
   logic [32:0] exq[$];
   logic [15:0] e;
   logic [5:0] r;
   // clock
   always #5 pclk = ~pclk;
   encoder_turns_and_line_scaling DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .step_in(step_in), .autoload_in(autoload_in), .switch_freq_sel(switch_freq_sel),
      .revolution_counter(revolution_counter), .reinit_trip(reinit_trip),
      .sample_rate_reduced(sample_rate_reduced), .irq(irq));
   enc_model u_enc (.pclk(pclk), .step_out(step_in), .load_out(autoload_in));
   // ----------------------------------------
   // apb master and checking
   // ----------------------------------------
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int t = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && t++ < 50);
      // a transfer that never completes counts against the run
      if (pready !== 1'b1) begin
         err_total++;
         $display("CHECK FAILED pready exp 1 got 0");
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic er = 1'b0);
      exq.push_back({er, d});
      xfer(1'b0, a, 32'h0);
   endtask
   task automatic close_out();
      if (exq.size() != 0) err_total++;
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // match each completed read against the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (exq.size() == 0) begin
            err_total++;
            $display("CHECK FAILED read_note exp 1 got 0");
         end else begin
            `CHK("prdata", exq[0][31:0], prdata)
            `CHK("pslverr", exq[0][32], pslverr)
            void'(exq.pop_front());
         end
      end
   end
   // watchdog against a hang
   initial begin
      #200us;
      err_total++;
      $display("CHECK FAILED watchdog exp 0 got 1");
      close_out();
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      void'($urandom(32'h65902b3d));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(`OFS_CTRL, 32'h0000A010);
      rd(`OFS_TURNS, 32'h00000010);
      rd(`OFS_LINES, 32'h00001000);
      rd(`OFS_POLES, 32'h00000002);
      rd(12'h028, 32'h0, 1'b1);
      // linear geometry keeps all 16 bits
      wr(`OFS_CTRL, 32'h0000A000);
      wr(`OFS_TURNS, 32'h00000005);
      u_enc.turn(1, 1'b1);
      rd(`OFS_REVS, 32'h0000FFFF);
      u_enc.turn(1, 1'b0);
      rd(`OFS_REVS, 32'h0);
      // rotary, five turns bits, both directions
      wr(`OFS_CTRL, 32'h0000A010);
      u_enc.turn(1, 1'b1);
      rd(`OFS_REVS, 32'h0000001F);
      `CHK("revolution_counter", 16'h001F, revolution_counter)
      u_enc.turn(1, 1'b0);
      rd(`OFS_REVS, 32'h0);
      n = $urandom_range(30, 1);
      u_enc.turn(n, 1'b0);
      rd(`OFS_REVS, n);
      u_enc.turn(31 - n, 1'b0);
      rd(`OFS_REVS, 32'h0000001F);
      u_enc.turn(1, 1'b0);
      rd(`OFS_REVS, 32'h0);
      // large setting clamps to 16 bits
      wr(`OFS_TURNS, 32'h000000C8);
      u_enc.turn(1, 1'b1);
      rd(`OFS_REVS, 32'h0000FFFF);
      u_enc.turn(1, 1'b0);
      wr(`OFS_TURNS, 32'h0);
      u_enc.turn(3, 1'b0);
      rd(`OFS_REVS, 32'h0);
      `CHK("revolution_counter", 16'h0000, revolution_counter)
      // lines change: trip and interrupt
      wr(`OFS_IRQ_MASK, 32'h00000001);
      wr(`OFS_LINES, 32'h00000400);
      rd(`OFS_STATUS, 32'h00000001);
      `CHK("reinit_trip", 1'b1, reinit_trip)
      `CHK("irq", 1'b1, irq)
      wr(`OFS_IRQ_MASK, 32'h0);
      // irq follows the mask one cycle after the write lands
      repeat (2) @(posedge pclk);
      `CHK("irq", 1'b0, irq)
      wr(`OFS_IRQ_MASK, 32'h00000001);
      wr(`OFS_STATUS, 32'h00000001);
      wr(`OFS_IRQ_STAT, 32'h0000000F);
      wr(`OFS_LINES, 32'h00000400);
      rd(`OFS_STATUS, 32'h0);
      `CHK("reinit_trip", 1'b0, reinit_trip)
      `CHK("irq", 1'b0, irq)
      // equivalent lines and resolution per type
      for (int k = 0; k < 7; k++) begin
         e = (k inside {1, 2, 4, 5}) ? 16'h0200 : 16'h0400;
         r = (k == 6) ? 6'h14 : ((k inside {1, 2, 4, 5}) ? 6'h0B : 6'h0C);
         wr(`OFS_CTRL, {16'h0, 4'hA, 6'h0, 2'h1, 4'(k)});
         rd(`OFS_SCALE, {10'h0, r, e});
      end
      wr(`OFS_CTRL, 32'h0000F016);
      rd(`OFS_SCALE, 32'h00150400);
      // rotary comms forces a power of two
      wr(`OFS_CTRL, 32'h0000A017);
      wr(`OFS_LINES, 32'h000003E8);
      rd(`OFS_LINES, 32'h00000200);
      wr(`OFS_LINES, 32'h00000001);
      rd(`OFS_LINES, 32'h00000002);
      wr(`OFS_LINES, 32'h0000FFFF);
      rd(`OFS_LINES, 32'h00008000);
      // single-turn comms bits, clamped to 32, give the resolution
      wr(`OFS_COMMS, 32'h0000003F);
      rd(`OFS_COMMS, 32'h00000020);
      rd(`OFS_SCALE, 32'h00208000);
      wr(`OFS_CTRL, 32'h0000A01C);
      rd(`OFS_CTRL, 32'h0000A017);
      // linear with lines not a power of two
      wr(`OFS_CTRL, 32'h0000A000);
      wr(`OFS_LINES, 32'h000003E8);
      rd(`OFS_LINES, 32'h000003E8);
      for (int s = 0; s < 4; s++) begin
         switch_freq_sel <= 2'(s);
         repeat (3) @(posedge pclk);
         `CHK("sample_rate_reduced", (s == 1 || s == 2), sample_rate_reduced)
      end
      // settings taken from an absolute encoder
      wr(`OFS_CTRL, 32'h0000A118);
      u_enc.load(8'h07, 16'h0800);
      rd(`OFS_TURNS, 32'h00000007);
      rd(`OFS_LINES, 32'h00000800);
      repeat (5) @(posedge pclk);
      close_out();
   end
endmodule // testbench
